// File: hdl/wdtm_top.sv
// Watchdog with selectable monitoring interval and latched over-temperature monitor, AXI4-Lite slave
// Summary of operation
// - After reset watchdog idle, indicator off
// - Timeout turns indicator red, notifies software
// - Normal mode: eight intervals 94 to 960 ms
// - Macro mode: eight intervals 2 to 64 s
// - Writing interval while running retriggers watchdog
// - Output bit 7 low lets reset through
// - Either temperature over threshold raises error
// - Error latched until cool and acknowledged
`timescale 1ns/10ps
`default_nettype none
module wdtm_top
  import wdtm_pkg::*;
#(
  parameter int MS_CYCLES = WDTM_CYC_PER_MS,
  parameter int TEMP_W    = 8
)(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [17:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [17:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Temperature readings
  input  wire logic [TEMP_W-1:0] cpu_temp,
  input  wire logic [TEMP_W-1:0] mem_temp,
  // Indicator, reset and interrupt
  output logic                   wd_led_red,
  output logic                   pc_reset,
  output logic                   irq
);

  // Interval in cycles, each mode from its own table
  function automatic logic [31:0] wdtm_interval(input logic macro, input logic [2:0] sel);
    logic [31:0] ms;
    ms = macro ? 32'(WDTM_MACRO_S[sel] * 1000) : 32'(WDTM_NORM_MS[sel]);
    return 32'(ms * MS_CYCLES);
  endfunction

  logic              aw_q, w_q;
  logic [17:0]       awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              wr_go, rd_go;
  logic              en_q, rsten_q, macro_q;
  logic [2:0]        sel_q;
  logic [7:0]        gpo_q;
  logic [1:0]        stat_q, mask_q;
  logic [TEMP_W-1:0] cpu_thr_q, mem_thr_q;
  logic [31:0]       cnt_q, limit;
  logic              kick, timeout, temp_hot, temp_ack, temp_err_q;
  logic [4:0]        rst_cnt_q;

  assign wr_go   = aw_q && w_q && !s_axi_bvalid;
  assign rd_go   = s_axi_arvalid && s_axi_arready;
  assign limit   = wdtm_interval(macro_q, sel_q);
  assign timeout = en_q && !wd_led_red && cnt_q == limit - 32'h1;
  assign temp_hot = cpu_temp > cpu_thr_q || mem_temp > mem_thr_q;

  // Address and data accepted in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 18'h00000;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      else if (wr_go)
        w_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= WDTM_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_q == WDTM_CTRL_ADDR || awaddr_q == WDTM_KICK_ADDR ||
                       awaddr_q == WDTM_STAT_ADDR || awaddr_q == WDTM_IRQ_ADDR ||
                       awaddr_q == WDTM_MASK_ADDR || awaddr_q == WDTM_THR_ADDR ||
                       awaddr_q == WDTM_GPO_ADDR) ? WDTM_RESP_OKAY : WDTM_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Control register; interval write also retriggers via kick
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_q    <= 1'b0;
      rsten_q <= 1'b0;
      macro_q <= 1'b1;
      sel_q   <= 3'h7;
    end
    else if (wr_go && awaddr_q == WDTM_CTRL_ADDR && wstrb_q[0])
    begin
      en_q    <= wdata_q[WDTM_CTRL_EN];
      rsten_q <= wdata_q[WDTM_CTRL_RSTEN];
      macro_q <= wdata_q[WDTM_CTRL_MACRO];
      sel_q   <= wdata_q[WDTM_CTRL_SEL +: 3];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gpo_q     <= WDTM_GPO_RESET;
      cpu_thr_q <= '1;
      mem_thr_q <= '1;
      mask_q    <= 2'h0;
    end
    else if (wr_go)
    begin
      if (awaddr_q == WDTM_GPO_ADDR && wstrb_q[WDTM_GPO_LANE])
        gpo_q <= wdata_q[8*WDTM_GPO_LANE +: 8];
      if (awaddr_q == WDTM_MASK_ADDR && wstrb_q[0])
        mask_q <= wdata_q[1:0];
      if (awaddr_q == WDTM_THR_ADDR)
      begin
        if (wstrb_q[0])
          cpu_thr_q <= wdata_q[TEMP_W-1:0];
        if (wstrb_q[2])
          mem_thr_q <= wdata_q[16 +: TEMP_W];
      end
    end
  end

  // Kick register write or any control register write restarts the count
  assign kick = wr_go && (awaddr_q == WDTM_KICK_ADDR || awaddr_q == WDTM_CTRL_ADDR);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !en_q || kick)
      cnt_q <= 32'h0;
    else if (!wd_led_red)
      cnt_q <= cnt_q + 32'h1;
  end

  // Indicator holds red until software disables or retriggers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wd_led_red <= 1'b0;
    else if (timeout)
      wd_led_red <= 1'b1;
    else if (kick || !en_q)
      wd_led_red <= 1'b0;
  end

  // Fixed-width reset pulse, gated by enable and output bit 7
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rst_cnt_q <= 5'h0;
      pc_reset  <= 1'b0;
    end
    else if (timeout && rsten_q && !gpo_q[WDTM_GPO_GATE])
    begin
      rst_cnt_q <= 5'(WDTM_RST_PULSE);
      pc_reset  <= 1'b1;
    end
    else if (rst_cnt_q != 5'h0)
    begin
      rst_cnt_q <= rst_cnt_q - 5'h1;
      pc_reset  <= rst_cnt_q != 5'h1;
    end
  end

  // Ack clears only once both readings are back at or under threshold
  assign temp_ack = wr_go && awaddr_q == WDTM_STAT_ADDR && wdata_q[WDTM_IRQ_TEMP];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      temp_err_q <= 1'b0;
    else if (temp_hot)
      temp_err_q <= 1'b1;
    else if (temp_ack)
      temp_err_q <= 1'b0;
  end

  // Sticky events; set beats write-one-to-clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stat_q <= 2'h0;
    else
    begin
      if (timeout)
        stat_q[WDTM_IRQ_WD] <= 1'b1;
      else if (wr_go && awaddr_q == WDTM_IRQ_ADDR && wdata_q[WDTM_IRQ_WD])
        stat_q[WDTM_IRQ_WD] <= 1'b0;
      if (temp_hot && !temp_err_q)
        stat_q[WDTM_IRQ_TEMP] <= 1'b1;
      else if (wr_go && awaddr_q == WDTM_IRQ_ADDR && wdata_q[WDTM_IRQ_TEMP])
        stat_q[WDTM_IRQ_TEMP] <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(stat_q & mask_q);
  end

  // Read channel, one outstanding read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_arready <= 1'b0;
    else
      s_axi_arready <= !s_axi_rvalid && !rd_go && !s_axi_arready;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= WDTM_RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= WDTM_RESP_OKAY;
      unique case (s_axi_araddr)
        WDTM_CTRL_ADDR: s_axi_rdata <= {25'h0, sel_q, 1'b0, macro_q, rsten_q, en_q};
        WDTM_KICK_ADDR: s_axi_rdata <= cnt_q;
        WDTM_STAT_ADDR: s_axi_rdata <= {29'h0, pc_reset, temp_err_q, wd_led_red};
        WDTM_IRQ_ADDR:  s_axi_rdata <= {30'h0, stat_q};
        WDTM_MASK_ADDR: s_axi_rdata <= {30'h0, mask_q};
        WDTM_THR_ADDR:  s_axi_rdata <= {8'h0, mem_thr_q, 8'h0, cpu_thr_q};
        WDTM_GPO_ADDR:  s_axi_rdata <= {24'h0, gpo_q};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= WDTM_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Checks
  sequence wd_expire_s;
    en_q && cnt_q == limit - 32'h1 && !wd_led_red && !kick;
  endsequence

  led_off_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !en_q && !$past(en_q) |-> !wd_led_red)
    else $error("indicator on while watchdog idle");

  timeout_led_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wd_expire_s |=> wd_led_red && stat_q[WDTM_IRQ_WD])
    else $error("timeout did not light indicator");

  reset_gated_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(pc_reset) |-> $past(rsten_q) && $past(timeout))
    else $error("reset without enabled reaction");

  gpo_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout && gpo_q[WDTM_GPO_GATE] && rst_cnt_q == 5'h0 |=> !pc_reset)
    else $error("reset passed closed gate");

  kick_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
    kick |=> cnt_q == 32'h0)
    else $error("retrigger did not restart count");

  full_interval_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(wd_led_red) |-> $past(cnt_q) == $past(limit) - 32'h1)
    else $error("timeout before full interval");

  temp_raise_a: assert property (@(posedge aclk) disable iff (!aresetn)
    temp_hot |=> temp_err_q)
    else $error("over-temperature not flagged");

  temp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    temp_err_q && !temp_ack |=> temp_err_q)
    else $error("temperature error dropped without ack");

  interval_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !macro_q && sel_q == 3'h0 |-> limit == 32'(94 * MS_CYCLES))
    else $error("normal interval wrong");

  macro_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    macro_q && sel_q == 3'h7 |-> limit == 32'(64000 * MS_CYCLES))
    else $error("macro interval wrong");

endmodule // wdtm_top
`default_nettype wire

// File: hdl/wdtm_pkg.sv
// Package with register map, field positions and timing constants for the watchdog and temperature monitor
package wdtm_pkg;
  // Register byte addresses; output port register keeps its word index, byte address is four times it
  localparam logic [15:0] WDTM_GPO_IDX     = 16'h404D;
  localparam logic [17:0] WDTM_GPO_ADDR    = {WDTM_GPO_IDX, 2'h0};
  localparam int          WDTM_GPO_LANE    = 0;
  localparam logic [17:0] WDTM_CTRL_ADDR   = 18'h00000;
  localparam logic [17:0] WDTM_KICK_ADDR   = 18'h00004;
  localparam logic [17:0] WDTM_STAT_ADDR   = 18'h00008;
  localparam logic [17:0] WDTM_IRQ_ADDR    = 18'h0000C;
  localparam logic [17:0] WDTM_MASK_ADDR   = 18'h00010;
  localparam logic [17:0] WDTM_THR_ADDR    = 18'h00014;
  // Control and output port fields
  localparam int          WDTM_CTRL_EN     = 0;
  localparam int          WDTM_CTRL_RSTEN  = 1;
  localparam int          WDTM_CTRL_MACRO  = 2;
  localparam int          WDTM_CTRL_SEL    = 4;
  localparam int          WDTM_GPO_GATE    = 7;
  localparam logic [7:0]  WDTM_GPO_RESET   = 8'h80;
  // Interrupt status bits
  localparam int          WDTM_IRQ_WD      = 0;
  localparam int          WDTM_IRQ_TEMP    = 1;
  // AXI responses
  localparam logic [1:0]  WDTM_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  WDTM_RESP_SLVERR = 2'h2;
  // Timing
  localparam int          WDTM_CLK_HZ      = 50_000_000;
  localparam int          WDTM_CYC_PER_MS  = WDTM_CLK_HZ / 1000;
  localparam int          WDTM_RST_PULSE   = 16;
  // Monitoring times, normal mode in ms, macro mode in s
  localparam int          WDTM_NORM_MS [8] = '{94, 210, 340, 460, 590, 710, 840, 960};
  localparam int          WDTM_MACRO_S [8] = '{2, 4, 6, 8, 16, 32, 48, 64};
endpackage : wdtm_pkg

// File: dv/wdtm_host.sv
// Host software model: AXI4-Lite master for the monitor registers
`timescale 1ns/10ps
`default_nettype none
module wdtm_host
  import wdtm_pkg::*;
(
  // Clock
  input  wire logic        aclk,
  // Write side
  output var logic [17:0]  s_axi_awaddr,
  output var logic         s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var logic [31:0]  s_axi_wdata,
  output var logic [3:0]   s_axi_wstrb,
  output var logic         s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var logic         s_axi_bready,
  // Read side
  output var logic [17:0]  s_axi_araddr,
  output var logic         s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var logic         s_axi_rready
);
  localparam logic MACRO_DEF = 1'b1; // Long intervals by default
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      // Released payload shows inverse, never a stale match
      if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
    end
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
    end
    while (s_axi_rvalid !== 1'b1);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task automatic cfg(input logic m, input logic [2:0] s, input logic rs, input logic en);
    logic [1:0] q;
    wr(WDTM_CTRL_ADDR, {25'h0, s, 1'b0, m, rs, en}, 4'h1, q); // Interval, reset, enable
  endtask
  task automatic gpo(input logic gate);
    logic [1:0] q;
    wr(WDTM_GPO_ADDR, {24'h0, gate, 7'h0}, 4'h1, q); // Low bit 7 lets reset out
  endtask
endmodule // wdtm_host
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the watchdog and temperature monitor
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import wdtm_pkg::*;
  localparam int MSC = 2;
  logic        aclk, aresetn, pr_q;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, wd_led_red, pc_reset, irq;
  logic [7:0]  cpu_temp, mem_temp, th [2];
  int          n_errors = 0, n_tests = 0, rst_cnt = 0;
  wdtm_top #(.MS_CYCLES(MSC), .TEMP_W(8)) i_wdtm_top (.*);
  wdtm_host i_wdtm_host (.*);
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    pr_q <= pc_reset;
    if (pc_reset === 1'b1 && pr_q !== 1'b1) rst_cnt <= rst_cnt + 1;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  function automatic int ivl(input logic m, input int s);
    return (m ? WDTM_MACRO_S[s] * 1000 : WDTM_NORM_MS[s]) * MSC;
  endfunction
  task automatic final_report;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic quiet;
    i_wdtm_host.cfg(1'b0, 3'h0, 1'b0, 1'b0);
    i_wdtm_host.wr(WDTM_IRQ_ADDR, 32'h3, 4'h1, rr);
    cyc(3);
    chk("irq cleared", irq, 0);
  endtask
  // Margin of 8 cycles covers bus latency around the retrigger
  task automatic expire(input logic m, input int s, input logic rs, input int npulse);
    int n;
    int c0;
    n = ivl(m, s);
    c0 = rst_cnt;
    i_wdtm_host.cfg(m, s[2:0], rs, 1'b1);
    cyc(n - 8);
    chk("led early", wd_led_red, 0);
    cyc(16);
    chk("led red", wd_led_red, 1);
    chk("irq wd", irq, 1);
    chk("resets", 32'(rst_cnt - c0), 32'(npulse));
    quiet();
    $display("test expire m%0d s%0d done", m, s);
  endtask
  initial
  begin
    cyc(40000);
    n_errors++;
    final_report();
  end
  initial
  begin
    aresetn = 1'b0;
    cpu_temp = 8'h00;
    mem_temp = 8'h00;
    void'($urandom(60));
    cyc(12);
    aresetn <= 1'b1;
    cyc(2);
    i_wdtm_host.rd(WDTM_CTRL_ADDR, rv, rr);
    chk("ctrl reset", rv[6:0], 7'h74);
    i_wdtm_host.rd(WDTM_GPO_ADDR, rv, rr);
    chk("gpo reset", rv[7:0], WDTM_GPO_RESET);
    i_wdtm_host.rd(18'h00100, rv, rr);
    chk("unmapped rd", rr, WDTM_RESP_SLVERR);
    i_wdtm_host.wr(18'h00100, 32'hFFFF_FFFF, 4'hF, rr);
    chk("unmapped wr", rr, WDTM_RESP_SLVERR);
    i_wdtm_host.wr(WDTM_MASK_ADDR, 32'h3, 4'h1, rr);
    chk("mask wr", rr, WDTM_RESP_OKAY);
    cyc(300);
    chk("idle outs", {wd_led_red, pc_reset, irq}, 0);
    $display("test reset done");
    expire(1'b0, 0, 1'b0, 0);
    i_wdtm_host.cfg(1'b0, 3'h0, 1'b0, 1'b1);
    repeat (3)
    begin
      cyc(ivl(1'b0, 0) - 30);
      i_wdtm_host.wr(WDTM_KICK_ADDR, 32'h1, 4'hF, rr);
    end
    cyc(ivl(1'b0, 0) - 30);
    i_wdtm_host.cfg(1'b0, 3'h0, 1'b0, 1'b1);
    cyc(100);
    chk("kept alive", wd_led_red, 0);
    quiet();
    $display("test retrigger done");
    expire(1'b0, 0, 1'b1, 0);
    expire(1'b0, 7, 1'b0, 0);
    expire(1'b0, int'($urandom_range(6, 1)), 1'b0, 0);
    i_wdtm_host.gpo(1'b0);
    expire(i_wdtm_host.MACRO_DEF, 0, 1'b1, 1);
    th[0] = 8'($urandom_range(200, 20));
    th[1] = 8'($urandom_range(200, 20));
    i_wdtm_host.wr(WDTM_THR_ADDR, {8'h0, th[1], 8'h0, th[0]}, 4'h5, rr);
    for (int k = 0; k < 2; k++)
    begin
      i_wdtm_host.wr(WDTM_MASK_ADDR, 32'(k * 2 + 1), 4'h1, rr);
      @(posedge aclk);
      if (k == 0) cpu_temp <= th[0] + 8'($urandom_range(31, 1));
      else mem_temp <= th[1] + 8'($urandom_range(31, 1));
      cyc(4);
      i_wdtm_host.rd(WDTM_IRQ_ADDR, rv, rr);
      chk("irq temp bit", rv[1], 1);
      chk("irq masking", irq, 32'(k));
      i_wdtm_host.wr(WDTM_STAT_ADDR, 32'h2, 4'h1, rr);
      i_wdtm_host.rd(WDTM_STAT_ADDR, rv, rr);
      chk("hot ack", rv[1], 1);
      @(posedge aclk);
      if (k == 0) cpu_temp <= th[0];
      else mem_temp <= th[1];
      cyc(4);
      i_wdtm_host.rd(WDTM_STAT_ADDR, rv, rr);
      chk("cool latched", rv[1], 1);
      i_wdtm_host.wr(WDTM_STAT_ADDR, 32'h2, 4'h1, rr);
      i_wdtm_host.rd(WDTM_STAT_ADDR, rv, rr);
      chk("cool ack", rv[1], 0);
      i_wdtm_host.wr(WDTM_IRQ_ADDR, 32'h2, 4'h1, rr);
      cyc(3);
      chk("irq w1c", irq, 0);
      $display("test temp %0d done", k);
    end
    final_report();
  end
endmodule // testbench
`default_nettype wire
